//--- common/ccd_pkg.sv
// constants and types for the clock output driver configuration bank
// What this block does
// - each of ten bank outputs has a power-down bit, 1 is down, resets 0
// - vcxo output has a power-down bit, 1 is down, resets 0
// - fractional output power-up bit, 0 powers output and whole channel down, resets 0
// - swing code 00/01/10/11 gives 350/500/700/850 mV; vcxo resets 00, others 01
// - swing mapping is the same for lvds and lvpecl formats
// - bank and fractional outputs have format bit, 0 lvds, 1 lvpecl, resets 0
// - vcxo two-bit format, 00 lvds, 01 lvpecl
// - vcxo format upper bit 1 gives antiphase lvcmos pair; field resets 10
// - fields are independent per bank output, banks of three, three, two, two
package ccd_pkg;

   // ----------------------------------------------------------------
   // slot layout
   // ----------------------------------------------------------------
   localparam int         NUM_BANK   = 10;
   localparam int         NUM_SLOT   = 12;
   localparam logic [3:0] SLOT_FRAC  = 4'hA;
   localparam logic [3:0] SLOT_VCXO  = 4'hB;
   localparam int         BANK_A_CNT = 3;
   localparam int         BANK_B_CNT = 3;
   localparam int         BANK_C_CNT = 2;
   localparam int         BANK_D_CNT = 2;

   // ----------------------------------------------------------------
   // per-output configuration word
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       pd;     // bank/vcxo: power-down, frac: power-up
      logic [1:0] fmt;    // bank/frac use bit 0 only
      logic [1:0] swing;
   } ccd_cfg_t;

   typedef enum logic [1:0] {
      VM_LVDS,
      VM_LVPECL,
      VM_LVCMOS
   } ccd_vmode_t;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] SWING_RST_STD  = 2'h1;
   localparam logic [1:0] SWING_RST_VCXO = 2'h0;
   localparam logic [1:0] FMT_RST_STD    = 2'h0;
   localparam logic [1:0] FMT_RST_VCXO   = 2'h2;
   localparam logic       PD_RST         = 1'h0;
   localparam logic       PU_RST_FRAC    = 1'h0;
   localparam ccd_cfg_t   CFG_RST_BANK   = '{PD_RST, FMT_RST_STD, SWING_RST_STD};
   localparam ccd_cfg_t   CFG_RST_FRAC   = '{PU_RST_FRAC, FMT_RST_STD, SWING_RST_STD};
   localparam ccd_cfg_t   CFG_RST_VCXO   = '{PD_RST, FMT_RST_VCXO, SWING_RST_VCXO};

   // ----------------------------------------------------------------
   // swing amplitude in mV
   // ----------------------------------------------------------------
   localparam logic [9:0] SWING_MV_0 = 10'h15E;
   localparam logic [9:0] SWING_MV_1 = 10'h1F4;
   localparam logic [9:0] SWING_MV_2 = 10'h2BC;
   localparam logic [9:0] SWING_MV_3 = 10'h352;

   function automatic logic [9:0] swing_mv(input logic [1:0] code);
      logic [9:0] mv;
      mv = SWING_MV_0;
      case (code)
         2'h0:    mv = SWING_MV_0;
         2'h1:    mv = SWING_MV_1;
         2'h2:    mv = SWING_MV_2;
         default: mv = SWING_MV_3;
      endcase
      return mv;
   endfunction

endpackage

//--- hw/ccd_out_slot.sv
// one output's configuration store
`timescale 1ns/1ps
`default_nettype none
module ccd_out_slot
   import ccd_pkg::*;
#(
   parameter ccd_cfg_t RST_VAL  = CFG_RST_BANK,
   parameter logic     WIDE_FMT = 1'b0
) (
   input  wire logic     clk,
   input  wire logic     reset,
   input  wire logic     wr_en,
   input  wire ccd_cfg_t wr_data,
   output var  ccd_cfg_t cfg
);

   // ----------------------------------------------------------------
   // stored fields, narrow format keeps upper bit zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg <= RST_VAL;
      end else if (wr_en) begin
         cfg.pd    <= wr_data.pd;
         cfg.swing <= wr_data.swing;
         cfg.fmt   <= {WIDE_FMT & wr_data.fmt[1], wr_data.fmt[0]};
      end
   end

endmodule
`default_nettype wire

//--- hw/ccd_out_cfg.sv
// clock output driver configuration bank top
`timescale 1ns/1ps
`default_nettype none
module ccd_out_cfg
   import ccd_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  cfg_wr_en,
   input  wire logic [3:0]            cfg_wr_slot,
   input  wire ccd_cfg_t              cfg_wr_data,
   input  wire logic                  cfg_rd_en,
   input  wire logic [3:0]            cfg_rd_slot,
   output var  ccd_cfg_t              cfg_rd_data,
   output logic                       cfg_rd_valid,
   input  wire logic [NUM_BANK-1:0]   bank_clock_src,
   input  wire logic                  frac_clock_src,
   input  wire logic                  vcxo_clock_src,
   output logic [NUM_BANK-1:0]        bank_clock_output,
   output logic                       frac_clock_output,
   output logic                       vcxo_clock_output,
   output logic                       vcxo_clock_output_comp,
   output logic [NUM_BANK-1:0]        bank_output_powerdown,
   output logic [NUM_BANK-1:0]        bank_format_lvpecl,
   output logic [NUM_BANK-1:0][1:0]   bank_swing_code,
   output logic                       frac_output_powerup,
   output logic                       frac_channel_powerdown,
   output logic                       frac_format_lvpecl,
   output logic [1:0]                 frac_swing_code,
   output logic                       vcxo_output_powerdown,
   output logic [1:0]                 vcxo_swing_code,
   output var  ccd_vmode_t            vcxo_mode,
   output logic [NUM_SLOT-1:0][9:0]   out_swing_mv
);

   // ----------------------------------------------------------------
   // configuration slots
   // ----------------------------------------------------------------
   ccd_cfg_t slot_cfg [NUM_SLOT];

   genvar g;
   generate
      for (g = 0; g < NUM_SLOT; g = g + 1) begin : g_slot
         localparam ccd_cfg_t RV = (g == int'(SLOT_VCXO)) ? CFG_RST_VCXO :
                                   (g == int'(SLOT_FRAC)) ? CFG_RST_FRAC : CFG_RST_BANK;
         logic wr_hit;
         assign wr_hit = cfg_wr_en && (cfg_wr_slot == 4'(g));
         ccd_out_slot #(
            .RST_VAL  (RV),
            .WIDE_FMT (g == int'(SLOT_VCXO))
         ) u_slot (
            .clk     (clk),
            .reset   (reset),
            .wr_en   (wr_hit),
            .wr_data (cfg_wr_data),
            .cfg     (slot_cfg[g])
         );
         // amplitude from code, independent of format
         always_ff @(posedge clk) begin
            if (reset) begin
               out_swing_mv[g] <= swing_mv(RV.swing);
            end else begin
               out_swing_mv[g] <= swing_mv(slot_cfg[g].swing);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // read back, unmapped slots read zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_rd_valid <= 1'b0;
      end else begin
         cfg_rd_valid <= cfg_rd_en;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_rd_data <= '0;
      end else if (cfg_rd_en) begin
         if (cfg_rd_slot < 4'(NUM_SLOT)) begin
            cfg_rd_data <= slot_cfg[cfg_rd_slot];
         end else begin
            cfg_rd_data <= '0;
         end
      end
   end

   // ----------------------------------------------------------------
   // bank outputs
   // ----------------------------------------------------------------
   generate
      for (g = 0; g < NUM_BANK; g = g + 1) begin : g_bank
         always_ff @(posedge clk) begin
            if (reset) begin
               bank_output_powerdown[g] <= CFG_RST_BANK.pd;
            end else begin
               bank_output_powerdown[g] <= slot_cfg[g].pd;
            end
         end

         always_ff @(posedge clk) begin
            if (reset) begin
               bank_format_lvpecl[g] <= CFG_RST_BANK.fmt[0];
            end else begin
               bank_format_lvpecl[g] <= slot_cfg[g].fmt[0];
            end
         end

         always_ff @(posedge clk) begin
            if (reset) begin
               bank_swing_code[g] <= CFG_RST_BANK.swing;
            end else begin
               bank_swing_code[g] <= slot_cfg[g].swing;
            end
         end

         always_ff @(posedge clk) begin
            if (reset) begin
               bank_clock_output[g] <= 1'b0;
            end else begin
               bank_clock_output[g] <= bank_clock_src[g] & ~slot_cfg[g].pd;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // fractional output
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         frac_output_powerup <= CFG_RST_FRAC.pd;
      end else begin
         frac_output_powerup <= slot_cfg[SLOT_FRAC].pd;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         frac_channel_powerdown <= ~CFG_RST_FRAC.pd;
      end else begin
         frac_channel_powerdown <= ~slot_cfg[SLOT_FRAC].pd;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         frac_format_lvpecl <= CFG_RST_FRAC.fmt[0];
      end else begin
         frac_format_lvpecl <= slot_cfg[SLOT_FRAC].fmt[0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         frac_swing_code <= CFG_RST_FRAC.swing;
      end else begin
         frac_swing_code <= slot_cfg[SLOT_FRAC].swing;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         frac_clock_output <= 1'b0;
      end else begin
         frac_clock_output <= frac_clock_src & slot_cfg[SLOT_FRAC].pd;
      end
   end

   // ----------------------------------------------------------------
   // vcxo output
   // ----------------------------------------------------------------
   ccd_vmode_t vmode_nxt;

   always_comb begin
      case (slot_cfg[SLOT_VCXO].fmt)
         2'h0:    vmode_nxt = VM_LVDS;
         2'h1:    vmode_nxt = VM_LVPECL;
         default: vmode_nxt = VM_LVCMOS;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         vcxo_output_powerdown <= CFG_RST_VCXO.pd;
      end else begin
         vcxo_output_powerdown <= slot_cfg[SLOT_VCXO].pd;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         vcxo_swing_code <= CFG_RST_VCXO.swing;
      end else begin
         vcxo_swing_code <= slot_cfg[SLOT_VCXO].swing;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         vcxo_mode <= VM_LVCMOS;
      end else begin
         vcxo_mode <= vmode_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         vcxo_clock_output      <= 1'b0;
         vcxo_clock_output_comp <= 1'b0;
      end else if (slot_cfg[SLOT_VCXO].pd) begin
         vcxo_clock_output      <= 1'b0;
         vcxo_clock_output_comp <= 1'b0;
      end else begin
         vcxo_clock_output      <= vcxo_clock_src;
         vcxo_clock_output_comp <= ~vcxo_clock_src;
      end
   end

endmodule
`default_nettype wire

//--- bench/ccd_out_cfg_chk.sv
// assertion checker for the output configuration bank
`timescale 1ns/1ps
`default_nettype none
module ccd_out_cfg_chk
   import ccd_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     reset,
   input wire logic                     cfg_wr_en,
   input wire logic [3:0]               cfg_wr_slot,
   input wire ccd_cfg_t                 cfg_wr_data,
   input wire logic                     cfg_rd_en,
   input wire logic                     cfg_rd_valid,
   input wire logic [NUM_BANK-1:0]      bank_clock_src,
   input wire logic [NUM_BANK-1:0]      bank_clock_output,
   input wire logic [NUM_BANK-1:0]      bank_output_powerdown,
   input wire logic                     frac_clock_src,
   input wire logic                     frac_clock_output,
   input wire logic                     frac_output_powerup,
   input wire logic                     frac_channel_powerdown,
   input wire logic [1:0]               frac_swing_code,
   input wire logic                     vcxo_clock_src,
   input wire logic                     vcxo_clock_output,
   input wire logic                     vcxo_clock_output_comp,
   input wire logic                     vcxo_output_powerdown,
   input wire ccd_vmode_t               vcxo_mode,
   input wire logic [NUM_SLOT-1:0][9:0] out_swing_mv
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wr_bank0; cfg_wr_en && cfg_wr_slot == 4'h0; endsequence
   sequence s_wr_vcxo; cfg_wr_en && cfg_wr_slot == SLOT_VCXO; endsequence
   a_rd_valid_pulse: assert property (!$past(reset) |-> cfg_rd_valid == $past(cfg_rd_en))
      else $error("read valid not one cycle after read strobe");
   a_bank_clk_gate: assert property (!$past(reset) |->
      bank_clock_output == ($past(bank_clock_src) & ~bank_output_powerdown))
      else $error("bank clock not gated by power-down");
   a_frac_clk_gate: assert property (!$past(reset) |->
      frac_clock_output == ($past(frac_clock_src) & frac_output_powerup))
      else $error("frac clock not gated by power-up");
   a_frac_chan_down: assert property (frac_channel_powerdown == !frac_output_powerup)
      else $error("frac channel power-down not inverse of power-up");
   a_vcxo_pair_run: assert property (!$past(reset) && !vcxo_output_powerdown |->
      vcxo_clock_output == $past(vcxo_clock_src) && vcxo_clock_output_comp != vcxo_clock_output)
      else $error("vcxo pair not in antiphase");
   a_vcxo_pair_off: assert property (vcxo_output_powerdown |->
      !vcxo_clock_output && !vcxo_clock_output_comp)
      else $error("vcxo pair toggles while powered down");
   a_wr_bank_pd: assert property (s_wr_bank0 |->
      ##2 bank_output_powerdown[0] == $past(cfg_wr_data.pd, 2))
      else $error("bank power-down write not applied after two cycles");
   a_wr_vcxo_mode: assert property (s_wr_vcxo |-> ##2 vcxo_mode ==
      ($past(cfg_wr_data.fmt[1], 2) ? VM_LVCMOS :
       $past(cfg_wr_data.fmt[0], 2) ? VM_LVPECL : VM_LVDS))
      else $error("vcxo mode does not follow format write");
   a_frac_swing_mv: assert property (out_swing_mv[10] ==
      (frac_swing_code == 2'h0 ? 10'h15E : frac_swing_code == 2'h1 ? 10'h1F4 :
       frac_swing_code == 2'h2 ? 10'h2BC : 10'h352))
      else $error("frac swing amplitude wrong");
endmodule
bind ccd_out_cfg ccd_out_cfg_chk chk_u (.*);
`default_nettype wire

//--- bench/test_clock_output_driver_config.sv
// self-checking bench for the output configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_clock_output_driver_config
   import ccd_pkg::*;
;
   logic clk = 0, reset = 1, cfg_wr_en = 0, cfg_rd_en = 0, cfg_rd_valid;
   logic [3:0] cfg_wr_slot = 0, cfg_rd_slot = 0;
   ccd_cfg_t cfg_wr_data = '0, cfg_rd_data;
   logic [NUM_BANK-1:0] bank_clock_src = 10'h155, bank_clock_output, bank_output_powerdown;
   logic [NUM_BANK-1:0] bank_format_lvpecl;
   logic [NUM_BANK-1:0][1:0] bank_swing_code;
   logic frac_clock_src = 0, vcxo_clock_src = 1, frac_clock_output, vcxo_clock_output;
   logic vcxo_clock_output_comp, frac_output_powerup, frac_channel_powerdown, frac_format_lvpecl;
   logic vcxo_output_powerdown;
   logic [1:0] frac_swing_code, vcxo_swing_code;
   ccd_vmode_t vcxo_mode;
   logic [NUM_SLOT-1:0][9:0] out_swing_mv;
   int fail_count = 0, n_tests = 0, cyc = 0;
   ccd_out_cfg dut_u (.*);
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         results();
      end
   end
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tick(); // sources toggle just after each edge
      @(posedge clk);
      #1;
      bank_clock_src = ~bank_clock_src;
      frac_clock_src = ~frac_clock_src;
      vcxo_clock_src = ~vcxo_clock_src;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask
   function automatic logic [9:0] mv(input logic [1:0] c);
      return c == 2'h0 ? 10'h15E : c == 2'h1 ? 10'h1F4 : c == 2'h2 ? 10'h2BC : 10'h352;
   endfunction
   task automatic wr(input logic [3:0] s, input logic [4:0] d);
      cfg_wr_en = 1; cfg_wr_slot = s; cfg_wr_data = d; tick();
   endtask
   task automatic rd(input logic [3:0] s, input logic [4:0] exp);
      cfg_rd_en = 1; cfg_rd_slot = s; tick();
      chk(cfg_rd_valid, 1); chk(cfg_rd_data, exp);
   endtask
   task automatic idle2();
      cfg_wr_en = 0; cfg_rd_en = 0; tick(); tick();
   endtask
   task automatic t_reset();
      for (int i = 0; i < 11; i++) rd(i, 5'h01);
      rd(4'hB, 5'h08);
      idle2();
      chk(vcxo_mode, VM_LVCMOS); chk(frac_channel_powerdown, 1);
      chk(frac_clock_output, 0); chk(out_swing_mv[11], 10'h15E);
   endtask
   task automatic t_bank();
      for (int i = 0; i < 10; i++) wr(i, {i[0], 2'h3, i[1:0]});
      idle2();
      for (int i = 0; i < 10; i++) begin
         chk(bank_output_powerdown[i], i[0]); chk(bank_format_lvpecl[i], 1);
         chk(bank_swing_code[i], i[1:0]); chk(out_swing_mv[i], mv(i[1:0]));
         chk(bank_clock_output[i], i[0] ? 1'b0 : !bank_clock_src[i]);
         rd(i, {i[0], 2'h1, i[1:0]});
      end
      cfg_rd_en = 0;
      wr(0, 5'h10);
      cfg_wr_en = 0;
      rd(0, 5'h10);
      idle2();
   endtask
   task automatic t_frac();
      wr(10, 5'h16);
      idle2();
      chk(frac_output_powerup, 1); chk(frac_channel_powerdown, 0);
      chk(frac_format_lvpecl, 1); chk(out_swing_mv[10], 10'h2BC);
      chk(frac_clock_output, !frac_clock_src);
      chk(frac_swing_code, 2'h2);
      rd(10, 5'h16);
      idle2();
   endtask
   task automatic t_vcxo();
      for (int f = 0; f < 4; f++) begin
         wr(11, {1'b0, f[1:0], 2'h3});
         idle2();
         chk(vcxo_mode, f[1] ? VM_LVCMOS : f[0] ? VM_LVPECL : VM_LVDS);
         chk(vcxo_swing_code, 3); chk(out_swing_mv[11], 10'h352);
         chk(vcxo_clock_output, !vcxo_clock_src);
         chk(vcxo_clock_output_comp, vcxo_clock_src);
      end
      wr(11, 5'h18);
      idle2();
      chk({vcxo_output_powerdown, vcxo_clock_output, vcxo_clock_output_comp}, 3'h4);
      wr(12, 5'h1F);
      cfg_wr_en = 0;
      rd(12, 5'h00);
      idle2();
   endtask
   task automatic t_rerun(); // reset again in mid-run
      reset = 1;
      tick();
      reset = 0;
      rd(0, 5'h01);
      rd(11, 5'h08);
      idle2();
      chk(vcxo_output_powerdown, 0); chk(bank_output_powerdown[0], 0);
      chk(vcxo_mode, VM_LVCMOS);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 reset = 0;
      t_reset();
      t_bank();
      t_frac();
      t_vcxo();
      t_rerun();
      results();
   end
endmodule
`default_nettype wire
